// >>> rtl/cfd_pkg.sv
// constants, types and helpers for the coil focus drive control block
// assumes a 25 MHz system clock and a 31.25 MHz link (drive) clock
package cfd_pkg;

	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned CLK_NS          = 40;
	localparam int unsigned CLK_PER_US      = CLK_HZ / 1_000_000;
	localparam int unsigned LINK_KHZ        = 31_250;
	localparam int unsigned SCL_TIMEOUT_US  = 500;
	localparam int unsigned SCL_TIMEOUT_CYC = SCL_TIMEOUT_US * CLK_PER_US;
	localparam int unsigned GLITCH_NS       = 50;
	// a spike can straddle two samples, so one sample more must agree
	localparam int unsigned FILT_CYC        = GLITCH_NS / CLK_NS + 2;
	localparam int unsigned RAMP_TICK_US    = 10;
	localparam int unsigned RAMP_TICK_CYC   = RAMP_TICK_US * CLK_PER_US;
	localparam int unsigned PWM_STEP_KHZ    = 500;

	localparam int CODE_W = 10;
	localparam int FSEL_W = 3;
	localparam int PER_W  = 7;

	localparam logic [9:0]  RAMP_STEP = 10'h004;
	localparam logic [7:0]  ADDR_CODE = 8'h00;
	localparam logic [7:0]  ADDR_MODE = 8'h04;
	localparam logic [7:0]  ADDR_CTRL = 8'h08;
	localparam logic [7:0]  ADDR_STAT = 8'h0C;

	localparam logic [9:0]  CODE_RST  = 10'h000;
	localparam logic        MODE_RST  = 1'b0;
	localparam logic [2:0]  FSEL_RST  = 3'h3;

	localparam int MODE_SW_BIT    = 0;
	localparam int STAT_SHORT_BIT = 2;
	localparam int STAT_BUSY_BIT  = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CFD_SHUTDOWN = 2'b00,
		CFD_STANDBY  = 2'b01,
		CFD_ACTIVE   = 2'b10
	} cfd_pwr_e;

	typedef struct packed {
		logic              enable;
		logic              switched;
		logic [FSEL_W-1:0] fsel;
		logic [CODE_W-1:0] code;
	} cfd_drive_cfg_s;

	// link cycles per switching period, 0.5 MHz steps from 0.5 MHz
	function automatic logic [PER_W-1:0] pwm_period(input logic [2:0] fsel);
		return PER_W'(LINK_KHZ / (PWM_STEP_KHZ * (int'(fsel) + 1)));
	endfunction

endpackage

// >>> rtl/cfd_ramp.sv
// coil current ramp toward the programmed code
// assumes system clock domain; run low forces the ramp back to zero
`timescale 1ns/1ps
module cfd_ramp (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       run,
	input  wire logic [9:0] target,
	output logic      [9:0] code_out,
	output logic            busy
);
	logic [15:0] tick_reg;
	logic        tick;
	logic [9:0]  code_reg;
	logic [9:0]  diff;

	assign tick     = (tick_reg == 16'(cfd_pkg::RAMP_TICK_CYC - 1));
	assign diff     = (target > code_reg) ? target - code_reg
	                                      : code_reg - target;
	assign busy     = run && (code_reg != target);
	assign code_out = code_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn || !run || tick)
			tick_reg <= 16'h0000;
		else
			tick_reg <= tick_reg + 16'h0001;
	end

	// a bounded slope keeps the lens spring from being kicked into ringing
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			code_reg <= cfd_pkg::CODE_RST;
		end else if (tick && busy) begin
			if (diff <= cfd_pkg::RAMP_STEP)
				code_reg <= target;
			else if (target > code_reg)
				code_reg <= code_reg + cfd_pkg::RAMP_STEP;
			else
				code_reg <= code_reg - cfd_pkg::RAMP_STEP;
		end
	end
endmodule // cfd_ramp

// >>> rtl/cfd_drive.sv
// output stage sequencer on the link clock
// assumes cfg is stable (handshake-captured) and over_ref already synchronised
`timescale 1ns/1ps
module cfd_drive (
	input  wire logic                    link_clk,
	input  wire logic                    link_rstn,
	input  wire cfd_pkg::cfd_drive_cfg_s cfg,
	input  wire logic                    over_ref,
	output logic                         hs_on,
	output logic                         ls_on,
	output logic                   [9:0] lin_level,
	output logic                   [9:0] dac_ref
);
	logic [6:0] cnt_reg;
	logic       wrap;

	assign wrap = (cnt_reg >= cfd_pkg::pwm_period(cfg.fsel) - 7'h01);

	always_ff @(posedge link_clk) begin
		if (!link_rstn || !cfg.enable || !cfg.switched || wrap)
			cnt_reg <= 7'h00;
		else
			cnt_reg <= cnt_reg + 7'h01;
	end

	always_ff @(posedge link_clk) begin
		if (!link_rstn || !cfg.enable) begin
			hs_on     <= 1'b0;
			ls_on     <= 1'b0;
			lin_level <= 10'h000;
		end else if (!cfg.switched) begin
			hs_on     <= 1'b1;
			ls_on     <= 1'b0;
			lin_level <= cfg.code;
		end else begin
			lin_level <= 10'h000;
			if (wrap) begin
				hs_on <= 1'b1;
				ls_on <= 1'b0;
			end else if (hs_on && over_ref) begin
				hs_on <= 1'b0;
				ls_on <= 1'b1;
			end
		end
	end

	// reference for the current error amplifier
	always_ff @(posedge link_clk) begin
		if (!link_rstn || !cfg.enable)
			dac_ref <= 10'h000;
		else
			dac_ref <= cfg.code;
	end
endmodule // cfd_drive

// >>> rtl/cfd_top.sv
// coil focus drive control: power states, registers, ramp and drive link
// assumes AXI4-Lite master on aclk; link_clk runs free from the drive side
`timescale 1ns/1ps
module cfd_top #(
	parameter int unsigned SCL_TIMEOUT_CYC = cfd_pkg::SCL_TIMEOUT_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        scl_pin,
	input  wire logic        sda_pin,
	output logic             scl_filt,
	output logic             sda_filt,
	input  wire logic        ilim_trip_pin,
	output logic [1:0]       pwr_state,
	input  wire logic        link_clk,
	input  wire logic        over_ref_pin,
	output logic             hs_on,
	output logic             ls_on,
	output logic [9:0]       lin_level,
	output logic [9:0]       dac_ref
);
	typedef cfd_pkg::cfd_drive_cfg_s cfd_cfg_t;

	// pin glitch filters
	logic [1:0] pin_in;
	logic [1:0] pin_filt;

	assign pin_in   = {sda_pin, scl_pin};
	assign scl_filt = pin_filt[0];
	assign sda_filt = pin_filt[1];

	genvar gi;
	for (gi = 0; gi < 2; gi++) begin : g_filt
		logic                         s0_reg;
		logic                         s1_reg;
		logic [cfd_pkg::FILT_CYC-1:0] hist_reg;
		logic                         filt_reg;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				s0_reg <= 1'b1;
				s1_reg <= 1'b1;
			end else begin
				s0_reg <= pin_in[gi];
				s1_reg <= s0_reg;
			end
		end

		// a new level must hold longer than the widest spike to pass;
		// with the synchroniser, 240 ns of delay is small against a 2.5 us bit time
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				hist_reg <= '1;
				filt_reg <= 1'b1;
			end else begin
				hist_reg <= {hist_reg[cfd_pkg::FILT_CYC-2:0], s1_reg};
				if (&hist_reg)
					filt_reg <= 1'b1;
				else if (~|hist_reg)
					filt_reg <= 1'b0;
			end
		end

		assign pin_filt[gi] = filt_reg;
	end

	// clock-low timeout and wake edge
	logic [15:0] low_cnt_reg;
	logic        scl_prev_reg;
	logic        scl_to;
	logic        scl_rise;

	assign scl_to   = (low_cnt_reg == 16'(SCL_TIMEOUT_CYC));
	assign scl_rise = scl_filt && !scl_prev_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn || scl_filt)
			low_cnt_reg <= 16'h0000;
		else if (!scl_to)
			low_cnt_reg <= low_cnt_reg + 16'h0001;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			scl_prev_reg <= 1'b1;
		else
			scl_prev_reg <= scl_filt;
	end

	// current-limit trip synchroniser
	logic ilim_s0_reg;
	logic ilim_s1_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ilim_s0_reg <= 1'b0;
			ilim_s1_reg <= 1'b0;
		end else begin
			ilim_s0_reg <= ilim_trip_pin;
			ilim_s1_reg <= ilim_s0_reg;
		end
	end

	// power state machine
	cfd_pkg::cfd_pwr_e pwr_reg;
	cfd_pkg::cfd_pwr_e pwr_next;
	logic [9:0]        code_reg;
	logic              mode_sw_reg;
	logic [2:0]        fsel_reg;
	logic              short_reg;
	logic              short_trip;
	logic              load_dflt;

	assign short_trip = ilim_s1_reg && (pwr_reg == cfd_pkg::CFD_ACTIVE);
	assign load_dflt  = (pwr_reg == cfd_pkg::CFD_SHUTDOWN) && scl_rise;
	assign pwr_state  = pwr_reg;

	always_comb begin
		pwr_next = pwr_reg;
		case (pwr_reg)
			cfd_pkg::CFD_SHUTDOWN: begin
				if (scl_rise)
					pwr_next = cfd_pkg::CFD_STANDBY;
			end
			cfd_pkg::CFD_STANDBY: begin
				if (scl_to)
					pwr_next = cfd_pkg::CFD_SHUTDOWN;
				else if (code_reg != 10'h000 && !short_reg)
					pwr_next = cfd_pkg::CFD_ACTIVE;
			end
			cfd_pkg::CFD_ACTIVE: begin
				if (scl_to)
					pwr_next = cfd_pkg::CFD_SHUTDOWN;
				else if (short_trip || code_reg == 10'h000)
					pwr_next = cfd_pkg::CFD_STANDBY;
			end
			default: pwr_next = cfd_pkg::CFD_SHUTDOWN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			pwr_reg <= cfd_pkg::CFD_STANDBY;
		else
			pwr_reg <= pwr_next;
	end

	// register bus slave
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  wr_addr_reg;
	logic [31:0] wr_data_reg;
	logic [3:0]  wr_strb_reg;
	logic        wr_fire;
	logic        ramp_busy;
	logic [9:0]  ramp_code;
	logic [31:0] rd_mux;

	function automatic logic addr_ok(input logic [7:0] a);
		return (a == cfd_pkg::ADDR_CODE) || (a == cfd_pkg::ADDR_MODE) ||
		       (a == cfd_pkg::ADDR_CTRL) || (a == cfd_pkg::ADDR_STAT);
	endfunction

	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready  = !w_held_reg;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (s_axi_awvalid && !aw_held_reg) begin
			aw_held_reg <= 1'b1;
			wr_addr_reg <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg  <= 1'b0;
			wr_data_reg <= 32'h00000000;
			wr_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && !w_held_reg) begin
			w_held_reg  <= 1'b1;
			wr_data_reg <= s_axi_wdata;
			wr_strb_reg <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= cfd_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_ok(wr_addr_reg) ? cfd_pkg::RESP_OKAY
			                                     : cfd_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// a wake writes defaults over any write landing in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn || load_dflt) begin
			code_reg    <= cfd_pkg::CODE_RST;
			mode_sw_reg <= cfd_pkg::MODE_RST;
			fsel_reg    <= cfd_pkg::FSEL_RST;
		end else if (wr_fire) begin
			if (wr_addr_reg == cfd_pkg::ADDR_CODE) begin
				if (wr_strb_reg[0])
					code_reg[7:0] <= wr_data_reg[7:0];
				if (wr_strb_reg[1])
					code_reg[9:8] <= wr_data_reg[9:8];
			end
			if (wr_addr_reg == cfd_pkg::ADDR_MODE && wr_strb_reg[0])
				mode_sw_reg <= wr_data_reg[cfd_pkg::MODE_SW_BIT];
			if (wr_addr_reg == cfd_pkg::ADDR_CTRL && wr_strb_reg[0])
				fsel_reg <= wr_data_reg[2:0];
		end
	end

	// short flag: trip sets, write-one clears, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn || load_dflt)
			short_reg <= 1'b0;
		else if (short_trip)
			short_reg <= 1'b1;
		else if (wr_fire && wr_addr_reg == cfd_pkg::ADDR_STAT &&
		         wr_strb_reg[0] && wr_data_reg[cfd_pkg::STAT_SHORT_BIT])
			short_reg <= 1'b0;
	end

	always_comb begin
		rd_mux = 32'h00000000;
		case (s_axi_araddr)
			cfd_pkg::ADDR_CODE: rd_mux[9:0] = code_reg;
			cfd_pkg::ADDR_MODE: rd_mux[cfd_pkg::MODE_SW_BIT] = mode_sw_reg;
			cfd_pkg::ADDR_CTRL: rd_mux[2:0] = fsel_reg;
			cfd_pkg::ADDR_STAT: begin
				rd_mux[1:0]                    = pwr_reg;
				rd_mux[cfd_pkg::STAT_SHORT_BIT] = short_reg;
				rd_mux[cfd_pkg::STAT_BUSY_BIT]  = ramp_busy;
			end
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= cfd_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= addr_ok(s_axi_araddr) ? cfd_pkg::RESP_OKAY
			                                      : cfd_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ringing-compensation ramp
	cfd_ramp u_ramp (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.run      (pwr_reg == cfd_pkg::CFD_ACTIVE),
		.target   (code_reg),
		.code_out (ramp_code),
		.busy     (ramp_busy)
	);

	// crossing to the drive domain: toggle request with held word
	cfd_cfg_t cfg_cur;
	cfd_cfg_t cfg_hold_reg;
	logic     req_tog_reg;
	logic     ack_s0_reg;
	logic     ack_s1_reg;
	logic     ack_tog_reg;

	always_comb begin
		cfg_cur.enable   = (pwr_reg == cfd_pkg::CFD_ACTIVE);
		cfg_cur.switched = mode_sw_reg;
		cfg_cur.fsel     = fsel_reg;
		cfg_cur.code     = ramp_code;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_s0_reg <= 1'b0;
			ack_s1_reg <= 1'b0;
		end else begin
			ack_s0_reg <= ack_tog_reg;
			ack_s1_reg <= ack_s0_reg;
		end
	end

	// the held word only changes once the previous one is acknowledged
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_hold_reg <= '0;
			req_tog_reg  <= 1'b0;
		end else if (req_tog_reg == ack_s1_reg && cfg_cur != cfg_hold_reg) begin
			cfg_hold_reg <= cfg_cur;
			req_tog_reg  <= !req_tog_reg;
		end
	end

	// link domain
	logic     lrst_s0_reg;
	logic     lrst_s1_reg;
	logic     req_s0_reg;
	logic     req_s1_reg;
	logic     ovr_s0_reg;
	logic     ovr_s1_reg;
	cfd_cfg_t cfg_link_reg;

	always_ff @(posedge link_clk) begin
		lrst_s0_reg <= aresetn;
		lrst_s1_reg <= lrst_s0_reg;
	end

	always_ff @(posedge link_clk) begin
		if (!lrst_s1_reg) begin
			req_s0_reg <= 1'b0;
			req_s1_reg <= 1'b0;
			ovr_s0_reg <= 1'b0;
			ovr_s1_reg <= 1'b0;
		end else begin
			req_s0_reg <= req_tog_reg;
			req_s1_reg <= req_s0_reg;
			ovr_s0_reg <= over_ref_pin;
			ovr_s1_reg <= ovr_s0_reg;
		end
	end

	always_ff @(posedge link_clk) begin
		if (!lrst_s1_reg) begin
			cfg_link_reg <= '0;
			ack_tog_reg  <= 1'b0;
		end else if (req_s1_reg != ack_tog_reg) begin
			cfg_link_reg <= cfg_hold_reg;
			ack_tog_reg  <= req_s1_reg;
		end
	end

	cfd_drive u_drive (
		.link_clk  (link_clk),
		.link_rstn (lrst_s1_reg),
		.cfg       (cfg_link_reg),
		.over_ref  (ovr_s1_reg),
		.hs_on     (hs_on),
		.ls_on     (ls_on),
		.lin_level (lin_level),
		.dac_ref   (dac_ref)
	);
endmodule // cfd_top

// >>> testbench/cfd_chk_sva.sv
// checker for the coil focus drive control top: power states, filter, drive
// assumes it is bound to cfd_top and sees only its ports
`timescale 1ns/1ps
module cfd_chk #(
	parameter int unsigned SCL_TIMEOUT_CYC = 12500
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       link_clk,
	input wire logic       scl_pin,
	input wire logic       scl_filt,
	input wire logic       ilim_trip_pin,
	input wire logic [1:0] pwr_state,
	input wire logic       hs_on,
	input wire logic       ls_on,
	input wire logic [9:0] lin_level,
	input wire logic [9:0] dac_ref
);
	logic [31:0] low_cnt;
	logic [4:0]  idle_cnt;
	logic [5:0]  act_cnt;

	// saturate so a long shutdown never wraps back into the early window
	always_ff @(posedge aclk) begin
		if (!aresetn || scl_filt) begin
			low_cnt <= 32'h0;
		end else if (low_cnt < 32'(SCL_TIMEOUT_CYC + 8)) begin
			low_cnt <= low_cnt + 32'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || pwr_state == 2'b10) begin
			idle_cnt <= 5'h0;
		end else if (idle_cnt != 5'h1F) begin
			idle_cnt <= idle_cnt + 5'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || pwr_state != 2'b10) begin
			act_cnt <= 6'h0;
		end else if (act_cnt != 6'h3F) begin
			act_cnt <= act_cnt + 6'h1;
		end
	end

	property p_sd_late;
		@(posedge aclk) disable iff (!aresetn)
		low_cnt == 32'(SCL_TIMEOUT_CYC + 4) |-> pwr_state == 2'b00;
	endproperty
	a_sd_late: assert property (p_sd_late)
		else $error("shutdown not entered after clock low timeout");

	property p_sd_early;
		@(posedge aclk) disable iff (!aresetn)
		!scl_filt && low_cnt < 32'(SCL_TIMEOUT_CYC - 2) &&
		$past(pwr_state) != 2'b00 |-> pwr_state != 2'b00;
	endproperty
	a_sd_early: assert property (p_sd_early)
		else $error("shutdown entered before clock low timeout");

	property p_wake;
		@(posedge aclk) disable iff (!aresetn)
		$rose(scl_filt) && pwr_state == 2'b00 |-> ##[1:2] pwr_state == 2'b01;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no standby after clock rise in shutdown");

	property p_glitch;
		@(posedge aclk) disable iff (!aresetn)
		$changed(scl_filt) |->
		$past(scl_pin, 4) == scl_filt && $past(scl_pin, 5) == scl_filt &&
		$past(scl_pin, 6) == scl_filt;
	endproperty
	a_glitch: assert property (p_glitch)
		else $error("filtered clock moved on a short pulse");

	property p_idle_off;
		@(posedge aclk) disable iff (!aresetn)
		idle_cnt == 5'h1F |-> !hs_on && !ls_on && lin_level == 10'h000
		&& dac_ref == 10'h000;
	endproperty
	a_idle_off: assert property (p_idle_off)
		else $error("output stage driving while not active");

	property p_act_on;
		@(posedge aclk) disable iff (!aresetn)
		act_cnt == 6'h3F |-> hs_on || ls_on;
	endproperty
	a_act_on: assert property (p_act_on)
		else $error("output stage idle while active");

	property p_trip;
		@(posedge aclk) disable iff (!aresetn)
		ilim_trip_pin && pwr_state == 2'b10 |-> ##[1:8] pwr_state == 2'b01;
	endproperty
	a_trip: assert property (p_trip)
		else $error("current limit trip did not drop to standby");

	property p_no_overlap;
		@(posedge link_clk) disable iff (!aresetn)
		!(hs_on && ls_on);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("high and low side on together");

	property p_fw_after_hs;
		@(posedge link_clk) disable iff (!aresetn)
		$rose(ls_on) |-> $past(hs_on);
	endproperty
	a_fw_after_hs: assert property (p_fw_after_hs)
		else $error("freewheel without a preceding charge phase");

	c_shutdown: cover property (@(posedge aclk) pwr_state == 2'b00);
	c_trip: cover property (@(posedge aclk) ilim_trip_pin && pwr_state == 2'b10);
	c_fw: cover property (@(posedge link_clk) $rose(ls_on));
endmodule // cfd_chk

bind cfd_top cfd_chk #(.SCL_TIMEOUT_CYC(SCL_TIMEOUT_CYC)) u_chk (
	.aclk(aclk), .aresetn(aresetn), .link_clk(link_clk), .scl_pin(scl_pin),
	.scl_filt(scl_filt), .ilim_trip_pin(ilim_trip_pin),
	.pwr_state(pwr_state), .hs_on(hs_on), .ls_on(ls_on),
	.lin_level(lin_level), .dac_ref(dac_ref)
);

// >>> testbench/cfd_coil_model.sv
// coil and sense comparator model on the drive side
// assumes hs_on and ls_on come from the link clock domain
`timescale 1ns/1ps
module cfd_coil_model (
	input wire logic link_clk,
	input wire logic hs_on,
	input wire logic ls_on,
	output logic     over_ref_pin
);
	initial over_ref_pin = 1'b0;
	// current crosses the reference one link cycle into a charge phase
	always @(posedge link_clk) begin
		over_ref_pin <= hs_on & ~ls_on;
	end
endmodule // cfd_coil_model

// >>> testbench/coil_focus_drive_control_tb.sv
// self-checking bench for cfd_top over AXI4-Lite and its pins
// assumes cfd_pkg constants; coil model answers the sense comparator
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED at %0t got %0h exp %0h", $time, (g), (e)); end end
module coil_focus_drive_control_tb;
	localparam int TO = 50;
	localparam int SCL_TO = 50;
	logic        aclk, aresetn, link_clk, scl_pin, sda_pin, scl_filt;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, pwr_state;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, sda_filt, ilim_trip_pin;
	logic        over_ref_pin, hs_on, ls_on;
	logic [9:0]  lin_level, dac_ref;
	int          num_errors, n_tests, per, s;

	cfd_top #(.SCL_TIMEOUT_CYC(SCL_TO)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.scl_pin(scl_pin), .sda_pin(sda_pin), .scl_filt(scl_filt),
		.sda_filt(sda_filt), .ilim_trip_pin(ilim_trip_pin),
		.pwr_state(pwr_state), .link_clk(link_clk),
		.over_ref_pin(over_ref_pin), .hs_on(hs_on), .ls_on(ls_on),
		.lin_level(lin_level), .dac_ref(dac_ref)
	);

	cfd_coil_model u_coil (
		.link_clk(link_clk), .hs_on(hs_on), .ls_on(ls_on),
		.over_ref_pin(over_ref_pin)
	);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	initial begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < TO; i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (i == TO) begin
			num_errors++;
			report_and_stop();
		end
		`CHK(s_axi_bresp, er)
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < TO; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (i == TO) begin
			num_errors++;
			report_and_stop();
		end
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, er)
	endtask

	task automatic wait_st(input logic [1:0] st, input int lim);
		int i;
		for (i = 0; i < lim && pwr_state !== st; i++) @(posedge aclk);
		`CHK(pwr_state, st)
		if (pwr_state !== st) report_and_stop();
	endtask

	// rise to rise of the charge phase, in link cycles
	task automatic meas(output int p);
		logic h0;
		int i;
		h0 = 1'b1;
		for (i = 0; i < 200 && !(hs_on && !h0); i++) begin
			h0 = hs_on;
			@(posedge link_clk);
		end
		p = 0;
		do begin
			h0 = hs_on;
			@(posedge link_clk);
			p++;
		end while (!(hs_on && !h0) && p < 200);
		if (i == 200 || p == 200) begin
			num_errors++;
			report_and_stop();
		end
	endtask

	initial begin
		num_errors = 0;
		n_tests = 0;
		aresetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, ilim_trip_pin} = 3'h0;
		{scl_pin, sda_pin} = 2'h3;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(cfd_pkg::ADDR_CODE, 32'h0, cfd_pkg::RESP_OKAY);
		axi_rd(cfd_pkg::ADDR_CTRL, 32'h3, cfd_pkg::RESP_OKAY);
		axi_rd(8'h10, 32'h0, cfd_pkg::RESP_SLVERR);
		axi_wr(8'h10, 32'h1, cfd_pkg::RESP_SLVERR);
		scl_pin <= 1'b0;
		@(posedge aclk);
		scl_pin <= 1'b1;
		for (s = 0; s < 8; s++) begin
			@(posedge aclk);
			`CHK(scl_filt, 1'b1)
		end
		sda_pin <= 1'b0;
		repeat (7) @(posedge aclk);
		`CHK(sda_filt, 1'b0)
		sda_pin <= 1'b1;
		axi_wr(cfd_pkg::ADDR_CODE, 32'h8, cfd_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		axi_rd(cfd_pkg::ADDR_STAT, 32'hA, cfd_pkg::RESP_OKAY);
		`CHK(lin_level > 10'h004, 1'b0)
		repeat (600) @(posedge aclk);
		axi_rd(cfd_pkg::ADDR_STAT, 32'h2, cfd_pkg::RESP_OKAY);
		`CHK({hs_on, ls_on, lin_level}, {2'b10, 10'h008})
		axi_wr(cfd_pkg::ADDR_MODE, 32'h1, cfd_pkg::RESP_OKAY);
		for (s = 0; s < 8; s++) begin
			axi_wr(cfd_pkg::ADDR_CTRL, 32'(s), cfd_pkg::RESP_OKAY);
			repeat (40) @(posedge aclk);
			meas(per);
			meas(per);
			`CHK(per, 31250 / (500 * (s + 1)))
			`CHK({lin_level, dac_ref}, {10'h000, 10'h008})
			@(posedge aclk);
		end
		ilim_trip_pin <= 1'b1;
		repeat (10) @(posedge aclk);
		ilim_trip_pin <= 1'b0;
		wait_st(2'b01, 20);
		axi_rd(cfd_pkg::ADDR_STAT, 32'h5, cfd_pkg::RESP_OKAY);
		axi_wr(cfd_pkg::ADDR_STAT, 32'h4, cfd_pkg::RESP_OKAY);
		wait_st(2'b10, 20);
		scl_pin <= 1'b0;
		repeat (SCL_TO - 20) @(posedge aclk);
		`CHK(pwr_state == 2'b00, 1'b0)
		wait_st(2'b00, 60);
		repeat (16) @(posedge aclk);
		`CHK({hs_on, ls_on, lin_level, dac_ref}, 22'h0)
		axi_wr(cfd_pkg::ADDR_CODE, 32'h20, cfd_pkg::RESP_OKAY);
		scl_pin <= 1'b1;
		wait_st(2'b01, 10);
		axi_rd(cfd_pkg::ADDR_CODE, 32'h0, cfd_pkg::RESP_OKAY);
		axi_rd(cfd_pkg::ADDR_MODE, 32'h0, cfd_pkg::RESP_OKAY);
		report_and_stop();
	end
endmodule // coil_focus_drive_control_tb
